/* File: verilog/bcrp_defines.svh */
`ifndef BCRP_DEFINES_SVH
`define BCRP_DEFINES_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define BCRP_OFS_DATA      8'ha0
`define BCRP_OFS_CTRL      8'ha4
`define BCRP_OFS_STAT      8'ha8
`define BCRP_OFS_IRQ_STAT  8'hb0
`define BCRP_OFS_IRQ_MASK  8'hb4
// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define BCRP_CTRL_START    31
`define BCRP_CTRL_DIR      30
`define BCRP_CTRL_RSVD_MSK 32'h000c0000
`define BCRP_STAT_ERR      1
`define BCRP_STAT_DONE     0
`define BCRP_RESET_VALUE   32'h00000000
// ----------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------
`define BCRP_FN_CLOCK_GEN  6'h01
`define BCRP_FN_TEMP       6'h04
`define BCRP_FN_BRD_RESET  6'h05
`define BCRP_FN_CFG_REG    6'h06
`define BCRP_FN_SHUTDOWN   6'h08
// ----------------------------------------------------------------
// Controller model latency in cycles
// ----------------------------------------------------------------
`define BCRP_CTL_LATENCY   4'h4
`endif

/* File: verilog/bcrp_pkg.sv */
package bcrp_pkg;
  typedef struct packed {
    logic       start;
    logic       transfer_direction;
    logic [3:0] board_controller_index;
    logic [5:0] function_code;
    logic [1:0] reserved;
    logic [1:0] site;
    logic [3:0] position;
    logic [11:0] device;
  } bcrp_ctrl_t;
  typedef enum logic [1:0] {
    BCRP_IDLE = 2'b00,
    BCRP_BUSY = 2'b01,
    BCRP_DONE = 2'b11
  } bcrp_state_t;
endpackage : bcrp_pkg

/* File: verilog/bcrp_link_if.sv */
`timescale 1ns/1ps
interface bcrp_link_if;
  logic        req_irq;
  logic [31:0] req_ctrl;
  logic [31:0] req_wdata;
  logic        done;
  logic        error;
  logic [31:0] rdata;
  modport port_end (output req_irq, output req_ctrl, output req_wdata,
                    input done, input error, input rdata);
  modport ctl_end  (input req_irq, input req_ctrl, input req_wdata,
                    output done, output error, output rdata);
endinterface : bcrp_link_if

/* File: verilog/bcrp_port.sv */
// Notes on behaviour
// [RULE1] Control register drives controller data transfers
// [RULE2] Writing bit 31 raises controller interrupt
// [RULE3] Bit 30: zero read, one write
// [RULE4] Bits 29:26 pick daughterboard controller
// [RULE5] Bits 25:20 give function code
// [RULE6] Software writes zeros, ignores bits 19:18
// [RULE7] Bits 17:16 select board site
// [RULE8] Bits 15:12 give stack position
// [RULE9] Bits 11:0 give device number
// [RULE10] Control write clears both status bits
// [RULE11] Completion bit low until operation done
// [RULE12] Controller returns read value into data
// [RULE13] Completion and error set together on finish
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "bcrp_defines.svh"
module bcrp_port
  import bcrp_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic             o_irq,
  bcrp_link_if.port_end    link
);
  logic [31:0] data_q;
  bcrp_ctrl_t  ctrl_q;
  logic [1:0]  stat_q;
  logic        busy_q;
  logic        kick_q;
  logic [1:0]  ev_q;
  logic [1:0]  mask_q;
  logic [31:0] rdata_q;
  logic        irq_q;
  logic        ctrl_wr;
  logic        finish;
  logic [1:0]  ev_set;
  logic        wr_data;
  logic        wr_istat;
  logic        wr_mask;
  logic [1:0]  ev_d;
  logic [1:0]  mask_d;
  logic [31:0] rdata_d;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Unmapped writes fall through and change nothing
  // Strobes are one cycle, so decode stays combinational
  assign ctrl_wr  = i_wr && (i_addr == `BCRP_OFS_CTRL);
  assign wr_data  = i_wr && (i_addr == `BCRP_OFS_DATA);
  assign wr_istat = i_wr && (i_addr == `BCRP_OFS_IRQ_STAT);
  assign wr_mask  = i_wr && (i_addr == `BCRP_OFS_IRQ_MASK);

  // ----------------------------------------------------------------
  // Completion from the controller
  // ----------------------------------------------------------------
  // Finish accepted only while a request is open
  // A control write in the same cycle wins: a start write restarts, a plain one closes
  assign finish   = busy_q && link.done && !ctrl_wr;
  // [RULE13] error only with completion
  assign ev_set   = {finish && link.error, finish};

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // [RULE1] control register store
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ctrl_q <= bcrp_ctrl_t'(`BCRP_RESET_VALUE);
    end else if (ctrl_wr) begin
      // [RULE6] reserved bits kept zero
      ctrl_q <= bcrp_ctrl_t'(i_wdata & ~`BCRP_CTRL_RSVD_MSK);
    end
  end

  // Controller return wins over a software data write
  // [RULE12] read data lands in data word
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      data_q <= `BCRP_RESET_VALUE;
    end else if (finish && !ctrl_q.transfer_direction) begin
      data_q <= link.rdata;
    end else if (wr_data) begin
      data_q <= i_wdata;
    end
  end

  // One pulse per start write; the controller
  // acts on it only when idle
  // [RULE2] start pulse on bit 31
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      kick_q <= 1'b0;
    end else begin
      kick_q <= ctrl_wr && i_wdata[`BCRP_CTRL_START];
    end
  end

  // [RULE10] clear on control write
  // [RULE11] done low while outstanding
  // [RULE13] done and error together
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      stat_q <= 2'h0;
    end else if (ctrl_wr) begin
      stat_q <= 2'h0;
    end else if (finish) begin
      stat_q <= {link.error, 1'b1};
    end
  end

  // Open request tracker; a plain control write closes it
  // so a late finish from the controller is dropped
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      busy_q <= 1'b0;
    end else if (ctrl_wr) begin
      busy_q <= i_wdata[`BCRP_CTRL_START];
    end else if (finish) begin
      busy_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // Set wins over a write-one clear in the same cycle
  always_comb begin
    ev_d = ev_q | ev_set;
    if (wr_istat) begin
      ev_d = (ev_q & ~i_wdata[1:0]) | ev_set;
    end
  end

  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = i_wdata[1:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ev_q <= 2'h0;
    end else begin
      ev_q <= ev_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mask_q <= 2'h0;
    end else begin
      mask_q <= mask_d;
    end
  end

  // Next values feed the line, so a clear or unmask
  // shows at the very next edge, not one later
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ev_d & mask_d);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read data stands one cycle only, zero otherwise
  always_comb begin
    rdata_d = 32'h0;
    if (i_rd) begin
      case (i_addr)
        `BCRP_OFS_DATA:     rdata_d = data_q;
        `BCRP_OFS_CTRL:     rdata_d = 32'(ctrl_q);
        `BCRP_OFS_STAT:     rdata_d = {30'h0, stat_q};
        `BCRP_OFS_IRQ_STAT: rdata_d = {30'h0, ev_q};
        `BCRP_OFS_IRQ_MASK: rdata_d = {30'h0, mask_q};
        default:            rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  // Fields pass as one word; controller decodes them
  // [RULE3] direction to controller
  // [RULE4] [RULE5] [RULE7] [RULE8] [RULE9] fields forwarded
  assign link.req_ctrl  = 32'(ctrl_q);
  assign link.req_wdata = data_q;
  assign link.req_irq   = kick_q;
  assign o_rdata        = rdata_q;
  assign o_irq          = irq_q;
endmodule : bcrp_port

/* File: verilog/bcrp_ctl.sv */
`timescale 1ns/1ps
`include "bcrp_defines.svh"
module bcrp_ctl
  import bcrp_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic [31:0] i_read_value,
  input  wire logic        i_fail,
  output logic             o_req,
  output logic             o_write,
  output logic [31:0]      o_ctrl,
  output logic [31:0]      o_wdata,
  bcrp_link_if.ctl_end     link
);
  bcrp_state_t state_q;
  bcrp_ctrl_t  req_q;
  logic [3:0]  cnt_q;
  logic [31:0] rd_q;
  logic        err_q;
  logic        req_o_q;
  logic        fn_ok;

  assign req_q  = bcrp_ctrl_t'(link.req_ctrl);
  // [RULE5] known function codes only
  assign fn_ok  = (req_q.function_code == `BCRP_FN_CLOCK_GEN) ||
                  (req_q.function_code == `BCRP_FN_TEMP) ||
                  (req_q.function_code == `BCRP_FN_BRD_RESET) ||
                  (req_q.function_code == `BCRP_FN_CFG_REG) ||
                  (req_q.function_code == `BCRP_FN_SHUTDOWN);

  // ----------------------------------------------------------------
  // Request handling
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q <= BCRP_IDLE;
      cnt_q   <= 4'h0;
      rd_q    <= 32'h0;
      err_q   <= 1'b0;
      req_o_q <= 1'b0;
    end else begin
      req_o_q <= 1'b0;
      case (state_q)
        BCRP_IDLE: begin
          if (link.req_irq) begin
            state_q <= BCRP_BUSY;
            cnt_q   <= `BCRP_CTL_LATENCY;
            req_o_q <= 1'b1;
          end
        end
        BCRP_BUSY: begin
          if (cnt_q == 4'h1) begin
            state_q <= BCRP_DONE;
            // [RULE7] only motherboard or daughter site
            err_q   <= i_fail || !fn_ok || req_q.site[1];
            // [RULE12] return read value
            rd_q    <= i_read_value;
          end
          cnt_q <= cnt_q - 4'h1;
        end
        BCRP_DONE: begin
          state_q <= BCRP_IDLE;
        end
        default: begin
          state_q <= BCRP_IDLE;
        end
      endcase
    end
  end

  assign link.done  = (state_q == BCRP_DONE);
  assign link.error = err_q;
  assign link.rdata = rd_q;
  assign o_req      = req_o_q;
  // [RULE3] direction bit
  assign o_write    = req_q.transfer_direction;
  assign o_ctrl     = link.req_ctrl;
  assign o_wdata    = link.req_wdata;
endmodule : bcrp_ctl

/* File: testbench/bcrp_link_monitor.sv */
`timescale 1ns/1ps
`include "bcrp_defines.svh"
module bcrp_link_monitor (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        req_irq,
  input  wire logic [31:0] req_ctrl,
  input  wire logic        done,
  input  wire logic        error
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  sequence s_launch; req_irq && req_ctrl[`BCRP_CTRL_START]; endsequence
  sequence s_finish; ##5 done ##1 !done; endsequence
  property p_irq_start; req_irq |-> req_ctrl[`BCRP_CTRL_START]; endproperty
  property p_irq_pulse; req_irq |=> !req_irq; endproperty
  property p_done_lat; s_launch |-> s_finish; endproperty
  property p_done_cause; done |-> $past(req_irq, 5); endproperty
  property p_fn_err;
    done && !(req_ctrl[25:20] inside {`BCRP_FN_CLOCK_GEN, `BCRP_FN_TEMP,
      `BCRP_FN_BRD_RESET, `BCRP_FN_CFG_REG, `BCRP_FN_SHUTDOWN}) |-> error;
  endproperty
  property p_site_err; done && req_ctrl[17] |-> error; endproperty
  property p_ctrl_hold; req_irq |=> $stable(req_ctrl)[*5]; endproperty
  property p_quiet; req_irq |=> !done[*4]; endproperty
  a_irq_start: assert property (p_irq_start)
    else $error("launch without start bit");
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("launch longer than one cycle");
  a_done_lat: assert property (p_done_lat)
    else $error("finish not five cycles after launch");
  a_done_cause: assert property (p_done_cause)
    else $error("finish without launch");
  a_fn_err: assert property (p_fn_err)
    else $error("unknown function without error");
  a_site_err: assert property (p_site_err)
    else $error("bad site without error");
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("request word moved while busy");
  a_quiet: assert property (p_quiet)
    else $error("finish too early");
endmodule : bcrp_link_monitor

/* File: testbench/bcrp_port_tb.sv */
`timescale 1ns/1ps
module bcrp_port_tb;
  logic        i_clock = 0, i_reset = 1, i_wr = 0, i_rd = 0, i_fail = 0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = '0, i_read_value = '0, o_rdata, o_ctrl, o_wdata;
  logic        o_irq, o_req, o_write;
  int          err_count = 0, compares = 0, cyc = 0, reqs = 0, starts = 0;
  logic [31:0] seed = 32'h61845ce7;
  logic [5:0]  fns [7] = '{6'h01, 6'h04, 6'h05, 6'h06, 6'h08, 6'h3f, 6'h01};
  bcrp_link_if bcrp_link_if_i();
  bcrp_port bcrp_port_i(.i_clock, .i_reset, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_irq, .link(bcrp_link_if_i));
  bcrp_ctl bcrp_ctl_i(.i_clock, .i_reset, .i_read_value, .i_fail, .o_req,
    .o_write, .o_ctrl, .o_wdata, .link(bcrp_link_if_i));
  bcrp_link_monitor bcrp_link_monitor_i(.i_clock, .i_reset,
    .req_irq(bcrp_link_if_i.req_irq), .req_ctrl(bcrp_link_if_i.req_ctrl),
    .done(bcrp_link_if_i.done), .error(bcrp_link_if_i.error));
  always #2.5 i_clock = ~i_clock;
  // Hang guard, run needs about 180 cycles
  always @(posedge i_clock) begin
    cyc++;
    if (o_req === 1'b1) reqs++;
    if (cyc == 1000) begin
      err_count++;
      stop_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic exp_err(input logic [31:0] c, input logic f);
    return f || c[17] || !(c[25:20] inside {6'h01, 6'h04, 6'h05, 6'h06, 6'h08});
  endfunction : exp_err
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask : rd
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d, c;
    logic        e;
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    // Unmapped 0xac and 0xb8 read zero
    foreach (fns[i]) rd(8'ha0 + 8'(i * 4), 32'h0);
    for (int i = 0; i < 7; i++) begin
      d = rnd();
      c = rnd();
      c[31] = (i != 6);
      c[25:20] = fns[i];
      c[19:18] = 2'b00;
      c[17] = (i == 4);
      @(posedge i_clock);
      i_read_value <= d;
      i_fail <= d[3];
      e = exp_err(c, d[3]);
      wr(8'hb4, (i == 3) ? 32'h0 : 32'h3);
      wr(8'ha0, ~d);
      wr(8'ha4, c);
      rd(8'ha8, 32'h0);
      chk(o_ctrl, c);
      chk({31'h0, o_write}, {31'h0, c[30]});
      repeat (3) @(posedge i_clock);
      if (c[31]) begin
        starts++;
        rd(8'ha8, {30'h0, e, 1'b1});
        chk({31'h0, o_irq}, {31'h0, i != 3});
        if (c[30]) chk(o_wdata, ~d);
        rd(8'hb0, {30'h0, e, 1'b1});
        wr(8'hb0, 32'h3);
        rd(8'hb0, 32'h0);
        chk({31'h0, o_irq}, 32'h0);
        rd(8'ha0, c[30] ? ~d : d);
      end else begin
        // Plain control write must leave nothing open
        rd(8'ha8, 32'h0);
      end
      $display("test %0d done", i);
    end
    chk(32'(reqs), 32'(starts));
    stop_test();
  end
endmodule : bcrp_port_tb
